// ==== shared/pfd_map.svh ====
// Constants for the phase/frequency detector block
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

// Clock period of the sampling clock in ns (125 MHz)
`define PFD_CLK_PERIOD_NS 8
// Number of sampled inputs: reference and feedback
`define PFD_NUM_INPUTS 2
// Bit positions of the inputs inside the sampled input vector
`define PFD_IDX_REF 0
`define PFD_IDX_FB 1
// Reset value of the stored input levels
`define PFD_LEVEL_RESET 1'h0
// Reset values of the outputs
`define PFD_LOCK_RESET 1'h1
`define PFD_XOR_RESET 1'h0
`define PFD_DRIVE_RESET 1'h0
`define PFD_ENABLE_RESET 1'h0

`endif

// ==== shared/pfd_pkg.sv ====
// Types shared by the phase/frequency detector design files
package pfd_pkg;

  // Edge report for one sampled input
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pfd_edge_type;

  // Output driver pair of the edge comparator
  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } pfd_drive_type;

  // Drive mode of the edge comparator
  typedef enum logic [1:0] {
    mode_hiz,
    mode_up,
    mode_down
  } pfd_mode_type;

  // Twelve comparator states: mode plus reference and feedback levels.
  // Suffix gives reference then feedback level.
  // hiz_00/01/10/11 are states 1/6/7/8, up_* are 3/5/9/11, dn_* are 2/4/10/12.
  typedef enum logic [3:0] {
    st_hiz_00,
    st_hiz_01,
    st_hiz_10,
    st_hiz_11,
    st_up_00,
    st_up_01,
    st_up_10,
    st_up_11,
    st_dn_00,
    st_dn_01,
    st_dn_10,
    st_dn_11
  } pfd_state_type;

endpackage

// ==== rtl/pfd_edge_sense.sv ====
// Rising and falling edge sensing for the sampled comparator inputs
`timescale 1ns/10ps
`include "pfd_map.svh"

module pfd_edge_sense
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PFD_NUM_INPUTS-1:0] level_in,
  output pfd_edge_type [`PFD_NUM_INPUTS-1:0] edge_out
);

  logic [`PFD_NUM_INPUTS-1:0] last_level;
  logic [`PFD_NUM_INPUTS-1:0] next_last_level;

  genvar gi;
  generate
    for (gi = 0; gi < `PFD_NUM_INPUTS; gi++)
    begin : g_in
      // Edge is a difference between this sample and the last one
      always_comb
      begin
        next_last_level[gi] = level_in[gi];
        edge_out[gi].level = level_in[gi];
        edge_out[gi].rise = level_in[gi] & ~last_level[gi];
        edge_out[gi].fall = ~level_in[gi] & last_level[gi];
      end

      // Last level starts low, so an input high at release counts as a rise
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          last_level[gi] <= `PFD_LEVEL_RESET;
        else
          last_level[gi] <= next_last_level[gi];
      end
    end
  endgenerate

endmodule

// ==== rtl/pfd_phase_detect.sv ====
// Phase detection logic: exclusive-OR comparator, edge phase/frequency comparator, oscillator gating
//
// Overview of operation
// - Exclusive-OR output follows reference XOR feedback one clock after either input changes.
// - XOR comparator phase spans zero to half cycle, quarter cycle at centre.
// - Edge comparator reacts only to rising edges, independent of duty cycle.
// - Edge comparator has four storage bits and separate pull-up, pull-down drivers.
// - Reference faster than feedback: mostly pull-up, otherwise floating, never pull-down.
// - Reference slower than feedback: mostly pull-down, otherwise floating.
// - Equal frequency, reference lagging: pull-down for the phase difference each cycle.
// - Equal frequency, feedback lagging: pull-up for the phase difference each cycle.
// - In phase and frequency: both drivers released, output floats.
// - Lock pulse output high while the comparator is released.
// - States three, five, nine and eleven enable the pull-up driver.
// - States two, four, ten and twelve enable the pull-down driver.
// - States one, six, seven, eight: drivers off, lock pulse output high.
// - Every other state drives the lock pulse output low.
// - Each state change comes from one level change on one input.
// - With no reference activity the comparator pulls down, toward lowest frequency.
// - Low disable input runs oscillator and follower; high stops both.
`timescale 1ns/10ps
`include "pfd_map.svh"

module pfd_phase_detect
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reference_in,
  input wire logic feedback_in,
  input wire logic oscillator_disable,
  output logic xor_detect_out,
  output logic edge_detect_out,
  output logic edge_detect_oe_n,
  output logic lock_pulse_out,
  output logic osc_enable,
  output logic follower_enable
);

  pfd_edge_type [`PFD_NUM_INPUTS-1:0] edges;
  pfd_edge_type ref_edge;
  pfd_edge_type fb_edge;
  pfd_state_type state;
  pfd_state_type next_state;
  pfd_drive_type drive;
  pfd_drive_type next_drive;
  logic lock;
  logic next_lock;
  logic xor_q;
  logic next_xor_q;
  logic run;
  logic next_run;

  // Mode held by a state
  function automatic pfd_mode_type state_mode(input pfd_state_type st);
    pfd_mode_type m;
    m = mode_hiz;
    unique case (st)
      st_hiz_00, st_hiz_01, st_hiz_10, st_hiz_11: m = mode_hiz;
      st_up_00, st_up_01, st_up_10, st_up_11: m = mode_up;
      st_dn_00, st_dn_01, st_dn_10, st_dn_11: m = mode_down;
      // Four spare codes of the state word fall back to released
      default: m = mode_hiz;
    endcase
    return m;
  endfunction

  // State from mode and the two input levels
  function automatic pfd_state_type make_state(input pfd_mode_type m, input logic s, input logic c);
    pfd_state_type st;
    st = st_hiz_00;
    unique case (m)
      mode_up: st = s ? (c ? st_up_11 : st_up_10) : (c ? st_up_01 : st_up_00);
      mode_down: st = s ? (c ? st_dn_11 : st_dn_10) : (c ? st_dn_01 : st_dn_00);
      default: st = s ? (c ? st_hiz_11 : st_hiz_10) : (c ? st_hiz_01 : st_hiz_00);
    endcase
    return st;
  endfunction

  // Edge sensing on both comparator inputs
  pfd_edge_sense u_sense (
    .clk(clk),
    .rst(rst),
    .level_in({feedback_in, reference_in}),
    .edge_out(edges)
  );

  assign ref_edge = edges[`PFD_IDX_REF];
  assign fb_edge = edges[`PFD_IDX_FB];

  // Edge comparator: only rising edges move the mode, falling ones only track levels
  always_comb
  begin
    pfd_mode_type m;
    m = state_mode(state);
    if (ref_edge.rise)
      m = (m == mode_down) ? mode_hiz : mode_up;
    // Both rising in one sample is outside the assumed input set; applied as reference then feedback
    if (fb_edge.rise)
      m = (m == mode_up) ? mode_hiz : mode_down;
    next_state = make_state(m, ref_edge.level, fb_edge.level);
  end

  // Output decode from the next state, so outputs come straight from flip-flops
  always_comb
  begin
    next_drive = '{pull_up: 1'h0, pull_down: 1'h0};
    next_lock = 1'h0;
    unique case (state_mode(next_state))
      mode_up: next_drive.pull_up = 1'h1;
      mode_down: next_drive.pull_down = 1'h1;
      mode_hiz: next_lock = 1'h1;
      // Spare mode code never occurs; treated as released
      default: next_lock = 1'h1;
    endcase
  end

  // Exclusive-OR comparator; average phase sits mid-range at the centre frequency
  always_comb
  begin
    next_xor_q = reference_in ^ feedback_in;
    next_run = ~oscillator_disable;
  end

  // State and output registers; reset leaves the comparator released
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_hiz_00;
      drive <= '{pull_up: `PFD_DRIVE_RESET, pull_down: `PFD_DRIVE_RESET};
      lock <= `PFD_LOCK_RESET;
      xor_q <= `PFD_XOR_RESET;
      run <= `PFD_ENABLE_RESET;
    end
    else
    begin
      state <= next_state;
      drive <= next_drive;
      lock <= next_lock;
      xor_q <= next_xor_q;
      run <= next_run;
    end
  end

  // Three-state output: enable low while either driver is on
  assign edge_detect_out = drive.pull_up;
  assign edge_detect_oe_n = ~(drive.pull_up | drive.pull_down);
  assign lock_pulse_out = lock;
  assign xor_detect_out = xor_q;
  assign osc_enable = run;
  assign follower_enable = run;

endmodule

// ==== verif/pfd_phase_detect_properties.sv ====
// Port checker for the phase detection block
`timescale 1ns/10ps
module pfd_phase_detect_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reference_in,
  input wire logic feedback_in,
  input wire logic oscillator_disable,
  input wire logic xor_detect_out,
  input wire logic edge_detect_out,
  input wire logic edge_detect_oe_n,
  input wire logic lock_pulse_out,
  input wire logic osc_enable,
  input wire logic follower_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Edges seen on the first sample after reset come from cleared levels, so skip it
  chk_xor_follows: assert property (
    !$past(rst) |-> xor_detect_out == $past(reference_in ^ feedback_in)) else $error("xor output wrong");
  chk_lock_float: assert property (
    lock_pulse_out == edge_detect_oe_n) else $error("lock flag disagrees with float");
  chk_ref_up: assert property (
    !$past(rst) && $rose(reference_in) && !$rose(feedback_in) && edge_detect_oe_n
    |=> !edge_detect_oe_n && edge_detect_out) else $error("no pull-up after lead");
  chk_ref_release: assert property (
    !$past(rst) && $rose(reference_in) && !$rose(feedback_in) && !edge_detect_oe_n && !edge_detect_out
    |=> edge_detect_oe_n) else $error("pull-down not released");
  chk_fb_down: assert property (
    !$past(rst) && $rose(feedback_in) && !$rose(reference_in) && edge_detect_oe_n
    |=> !edge_detect_oe_n && !edge_detect_out) else $error("no pull-down after lag");
  chk_fb_release: assert property (
    !$past(rst) && $rose(feedback_in) && !$rose(reference_in) && !edge_detect_oe_n && edge_detect_out
    |=> edge_detect_oe_n) else $error("pull-up not released");
  chk_hold_still: assert property (
    !$past(rst) && !$rose(reference_in) && !$rose(feedback_in)
    |=> $stable(edge_detect_oe_n) && $stable(edge_detect_out)) else $error("drive moved without rise");
  chk_osc_gate: assert property (
    !$past(rst) |-> osc_enable == !$past(oscillator_disable)) else $error("oscillator gate wrong");
  chk_follower_gate: assert property (
    follower_enable == osc_enable) else $error("follower gate wrong");
  cover property (!edge_detect_oe_n && edge_detect_out);
  cover property (!edge_detect_oe_n && !edge_detect_out);
  cover property ($rose(lock_pulse_out));
endmodule

bind pfd_phase_detect pfd_phase_detect_properties pfd_phase_detect_properties_inst (
  .clk(clk), .rst(rst), .reference_in(reference_in), .feedback_in(feedback_in),
  .oscillator_disable(oscillator_disable), .xor_detect_out(xor_detect_out),
  .edge_detect_out(edge_detect_out), .edge_detect_oe_n(edge_detect_oe_n),
  .lock_pulse_out(lock_pulse_out), .osc_enable(osc_enable), .follower_enable(follower_enable));

// ==== verif/pfd_loop_model.sv ====
// Loop model: gated oscillator whose output returns as feedback
`timescale 1ns/10ps
module pfd_loop_model
(
  input wire logic clk,
  input wire logic osc_enable,
  input wire logic [7:0] half,
  output logic feedback = 1'b0
);
  logic [7:0] cnt = 8'h00;
  // Equal high and low time; a stopped oscillator parks low
  always @(posedge clk)
  begin
    if (!osc_enable)
    begin
      cnt <= 8'h00;
      feedback <= 1'b0;
    end
    // Compare with >= so a shorter half period takes effect without a counter wrap
    else if (cnt >= half - 8'h01)
    begin
      cnt <= 8'h00;
      feedback <= ~feedback;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// ==== verif/tb_top.sv ====
// Testbench for the phase detection block
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_drv = 1'b0;
  logic fb_drv = 1'b0;
  logic use_loop = 1'b0;
  logic dis = 1'b0;
  logic [7:0] half = 8'h03;
  logic loop_fb, xo, eo, oe_n, lock, osc_en, fol_en;
  int bad_count = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  pfd_loop_model pfd_loop_model_inst (.clk(clk), .osc_enable(osc_en), .half(half), .feedback(loop_fb));
  pfd_phase_detect pfd_phase_detect_inst (.clk(clk), .rst(rst), .reference_in(ref_drv),
    .feedback_in(use_loop ? loop_fb : fb_drv), .oscillator_disable(dis), .xor_detect_out(xo),
    .edge_detect_out(eo), .edge_detect_oe_n(oe_n), .lock_pulse_out(lock), .osc_enable(osc_en),
    .follower_enable(fol_en));
  task automatic check(input string name, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Reference leads: pull-up until feedback catches up; a falling edge changes nothing
  task automatic t_lead;
    @(posedge clk) ref_drv <= 1'b1;
    @(posedge clk) #1;
    check("up", eo, 1'b1);
    check("up_oe", oe_n, 1'b0);
    check("lock_lo", lock, 1'b0);
    @(posedge clk) ref_drv <= 1'b0;
    @(posedge clk) #1;
    check("fall_kept", oe_n, 1'b0);
    @(posedge clk) fb_drv <= 1'b1;
    @(posedge clk) #1;
    check("released", oe_n, 1'b1);
    check("lock_hi", lock, 1'b1);
    @(posedge clk) #1;
    check("xor_one", xo, 1'b1);
    @(posedge clk) fb_drv <= 1'b0;
  endtask
  // Reference lags: pull-down until the reference rises
  task automatic t_lag;
    @(posedge clk) fb_drv <= 1'b1;
    @(posedge clk) #1;
    check("down", eo, 1'b0);
    check("down_oe", oe_n, 1'b0);
    @(posedge clk) ref_drv <= 1'b1;
    @(posedge clk) #1;
    check("lag_free", oe_n, 1'b1);
    @(posedge clk) #1;
    check("xor_zero", xo, 1'b0);
    @(posedge clk) ref_drv <= 1'b0;
    @(posedge clk) fb_drv <= 1'b0;
  endtask
  // Feedback from the loop only, reference quiet, then a faster reference
  task automatic t_loop;
    int up;
    int dn;
    up = 0;
    dn = 0;
    @(posedge clk) use_loop <= 1'b1;
    repeat (24) @(posedge clk);
    #1;
    check("quiet_oe", oe_n, 1'b0);
    check("quiet_dn", eo, 1'b0);
    @(posedge clk) half <= 8'h07;
    for (int i = 0; i < 112; i++)
    begin
      @(posedge clk) if (i % 2 == 0) ref_drv <= ~ref_drv;
      #1;
      if (i > 28 && !oe_n) if (eo) up++; else dn++;
    end
    check("fast_no_dn", dn == 0, 1'b1);
    check("fast_mostly_up", up > 42, 1'b1);
  endtask
  // Reference slower than the loop: pull-down most of the time, never pull-up
  task automatic t_slow;
    int up;
    int dn;
    up = 0;
    dn = 0;
    @(posedge clk) half <= 8'h03;
    for (int i = 0; i < 160; i++)
    begin
      @(posedge clk) if (i % 8 == 0) ref_drv <= ~ref_drv;
      #1;
      if (i > 40 && !oe_n)
      begin
        if (eo)
          up++;
        else
          dn++;
      end
    end
    check("slow_no_up", up == 0, 1'h1);
    check("slow_mostly_dn", dn > 59, 1'h1);
    check("slow_driving", oe_n, 1'h0);
  endtask
  // Reset in mid-run while pulling down: comparator released, lock flag high
  task automatic t_reset;
    @(posedge clk) rst <= 1'h1;
    @(posedge clk) #1;
    check("mid_rst_oe", oe_n, 1'h1);
    check("mid_rst_lock", lock, 1'h1);
    @(posedge clk) rst <= 1'h0;
  endtask
  // Disable input gates oscillator and follower together
  task automatic t_gate;
    @(posedge clk) dis <= 1'b1;
    @(posedge clk) #1;
    check("osc_off", osc_en, 1'b0);
    check("fol_off", fol_en, 1'b0);
    @(posedge clk) dis <= 1'b0;
    @(posedge clk) #1;
    check("osc_on", osc_en, 1'b1);
    check("fol_on", fol_en, 1'h1);
  endtask
  initial
  begin
    // Reset starts high with no edge, so the reset branch first runs at the first clock
    @(posedge clk) #1;
    check("rst_oe", oe_n, 1'b1);
    check("rst_lock", lock, 1'b1);
    @(posedge clk) rst <= 1'b0;
    t_lead;
    t_lag;
    t_loop;
    t_slow;
    t_reset;
    t_gate;
    tally_and_finish;
  end
  initial
  begin
    #(8 * 1000);
    bad_count++;
    tally_and_finish;
  end
endmodule
